// ===== design/media_sense_regs.vh
// Constants for the media sense and general pin port
`ifndef MEDIA_SENSE_REGS_VH
`define MEDIA_SENSE_REGS_VH
`define GP_COUNT 6
`define SENSE_COUNT 2
`define PIN_COUNT 8
`define GP_DIR_RST 6'h38
`define GP_POL_RST 6'h00
`define GP_EDGE_RST 6'h07
`define GP_OUT_RST 6'h18
`define SENSE_POL_RST 2'h3
`define SENSE_EDGE_RST 2'h0
`define SENSE1_STOP_RST 1'h0
`define SENSE2_STOP_RST 1'h0
`define LINE_DELAY_RST 8'h00
`define ST_SENSE1_BIT 0
`define ST_SENSE2_BIT 1
`define ST_GP_LSB 2
`define D2_IDLE 2'h0
`define D2_WAIT 2'h1
`define D2_DONE 2'h2
`endif

// ===== design/pin_sync.v
// Two-stage synchronizer for a group of input pins
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire core_clk_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  always @(posedge core_clk_in) begin
    meta_r <= async_in;
    sync_r <= meta_r;
  end
  assign sync_out = sync_r;
endmodule // pin_sync

// ===== design/media_sense_io.v
// Media sense inputs and configurable general pins with clear-on-read status
//
// Functional notes
// R1: Eight pins: two dedicated sense inputs, six general bidirectional pins.
// R2: General pin direction bit: zero is input, one is output.
// R3: Polarity one: high level reads as true in status.
// R4: Polarity zero: low level reads as true in status.
// R5: Level mode: status bit follows polarity-adjusted input continuously.
// R6: Edge mode: status latches true on any false-to-true since last read.
// R7: Status read clears every edge-mode status bit.
// R8: Enabled sense 1 rising true clears scanning; stops scan and both moves.
// R9: Enabled sense 2 waits programmed lines, then sets status and clears scanning.
// R10: Sense 2 never stops a fast reverse move.
// R11: Output pin drives high for bit one, low for bit zero.
// R12: Power-on, suspend and reset pin restore general pin defaults.
// R13: Soft reset leaves general pin configuration and outputs unchanged.
// R14: Default pins one to three edge inputs, falling edge sets bits 2-4.
// R15: Default pins four, five drive high; pin six drives low.
// R16: Host selects register address once, then many data accesses.
// R17: Host avoids writing status registers.
// R18: Sense and general pin configuration writable while idle.
// R19: Every input pin passes two synchronizer stages before detection.
`timescale 1ns/1ps
`include "media_sense_regs.vh"
module media_sense_io #(
  parameter LINE_W = 8
) (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire suspend_in,
  input wire soft_reset_in,
  input wire idle_in,
  input wire line_tick_in,
  input wire fast_reverse_in,
  input wire scanning_in,
  input wire [`SENSE_COUNT-1:0] sense_pin_in,
  input wire [`GP_COUNT-1:0] gp_pin_in,
  output wire [`GP_COUNT-1:0] gp_pin_out,
  output wire [`GP_COUNT-1:0] gp_pin_oe_n_out,
  input wire cfg_we_in,
  input wire [`GP_COUNT-1:0] gp_dir_in,
  input wire [`GP_COUNT-1:0] gp_pol_in,
  input wire [`GP_COUNT-1:0] gp_edge_in,
  input wire [`GP_COUNT-1:0] gp_out_in,
  input wire [`SENSE_COUNT-1:0] sense_pol_in,
  input wire [`SENSE_COUNT-1:0] sense_edge_in,
  input wire sense1_stop_en_in,
  input wire sense2_stop_en_in,
  input wire [LINE_W-1:0] line_delay_in,
  input wire status_rd_in,
  output wire [`PIN_COUNT-1:0] status_out,
  output wire stop_scan_out,
  output wire [`GP_COUNT-1:0] gp_dir_out,
  output wire [`GP_COUNT-1:0] gp_pol_out,
  output wire [`GP_COUNT-1:0] gp_edge_out,
  output wire [`GP_COUNT-1:0] gp_out_val_out
);
  reg [`GP_COUNT-1:0] gp_dir_r;
  reg [`GP_COUNT-1:0] gp_pol_r;
  reg [`GP_COUNT-1:0] gp_edge_r;
  reg [`GP_COUNT-1:0] gp_out_r;
  reg [`SENSE_COUNT-1:0] sense_pol_r;
  reg [`SENSE_COUNT-1:0] sense_edge_r;
  reg sense1_stop_r;
  reg sense2_stop_r;
  reg [LINE_W-1:0] line_delay_r;
  reg [`PIN_COUNT-1:0] true_prev_r;
  reg [`PIN_COUNT-1:0] latch_r;
  reg [`PIN_COUNT-1:0] latch_nxt;
  reg [`PIN_COUNT-1:0] status_r;
  reg [`PIN_COUNT-1:0] status_nxt;
  reg [1:0] d2_state_r;
  reg [LINE_W-1:0] d2_cnt_r;
  reg sense2_true_r;
  reg stop_r;
  wire [`PIN_COUNT-1:0] pins_sync;
  wire [`PIN_COUNT-1:0] pol_all;
  wire [`PIN_COUNT-1:0] edge_all;
  wire [`PIN_COUNT-1:0] true_now;
  wire [`PIN_COUNT-1:0] rise;
  wire [`PIN_COUNT-1:0] level_or_latch;
  wire s1_rep_rise;
  wire s2_pin_rise;
  wire s2_fire;
  wire s1_stop_req;
  wire s2_stop_req;
  wire cfg_take;
  integer i;

  // Sense-2 delay machine states
  localparam [1:0] D2_IDLE = `D2_IDLE;
  localparam [1:0] D2_WAIT = `D2_WAIT;
  localparam [1:0] D2_DONE = `D2_DONE;
  localparam [LINE_W-1:0] CNT_ONE = {{(LINE_W-1){1'b0}}, 1'b1};

  // Polarity one keeps the pin level, zero inverts it
  function pol_true;
    input pin;
    input pol;
    begin
      pol_true = ~(pin ^ pol);
    end
  endfunction

  // Line counter has run out
  function cnt_zero;
    input [LINE_W-1:0] cnt;
    begin
      cnt_zero = (cnt == {LINE_W{1'b0}});
    end
  endfunction

  // Pin input stage
  pin_sync #(
    .WIDTH(`PIN_COUNT)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .async_in({gp_pin_in, sense_pin_in}),
    .sync_out(pins_sync)
  ); // R19

  // Settings restored by reset pin or suspend only; soft reset is ignored here
  assign cfg_take = cfg_we_in & idle_in; // R18

  // General pin direction, polarity, sensitivity and drive value
  always @(posedge core_clk_in) begin
    if (sys_rst_in | suspend_in) begin // R12 R13
      gp_dir_r <= `GP_DIR_RST; // R14 R15
      gp_pol_r <= `GP_POL_RST; // R14
      gp_edge_r <= `GP_EDGE_RST; // R14
      gp_out_r <= `GP_OUT_RST; // R15
    end else if (cfg_take) begin
      gp_dir_r <= gp_dir_in; // R2
      gp_pol_r <= gp_pol_in;
      gp_edge_r <= gp_edge_in;
      gp_out_r <= gp_out_in;
    end
  end

  // Sense pin polarity and sensitivity
  always @(posedge core_clk_in) begin
    if (sys_rst_in | suspend_in) begin
      sense_pol_r <= `SENSE_POL_RST;
      sense_edge_r <= `SENSE_EDGE_RST;
    end else if (cfg_take) begin
      sense_pol_r <= sense_pol_in;
      sense_edge_r <= sense_edge_in;
    end
  end

  // Stop enables and line delay
  always @(posedge core_clk_in) begin
    if (sys_rst_in | suspend_in) begin
      sense1_stop_r <= `SENSE1_STOP_RST;
      sense2_stop_r <= `SENSE2_STOP_RST;
      line_delay_r <= `LINE_DELAY_RST;
    end else if (cfg_take) begin
      sense1_stop_r <= sense1_stop_en_in;
      sense2_stop_r <= sense2_stop_en_in;
      line_delay_r <= line_delay_in;
    end
  end

  // Active-low output enable: low while driving
  genvar g;
  generate
    for (g = 0; g < `GP_COUNT; g = g + 1) begin : gp_drv
      assign gp_pin_out[g] = gp_out_r[g]; // R11
      assign gp_pin_oe_n_out[g] = ~gp_dir_r[g]; // R1 R2
    end
  endgenerate

  assign pol_all = {gp_pol_r, sense_pol_r};
  assign edge_all = {gp_edge_r, sense_edge_r};

  // Per-pin polarity, rise detect and level or edge select
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1) begin : pin_det
      assign true_now[g] = pol_true(pins_sync[g], pol_all[g]); // R3 R4
      assign rise[g] = true_now[g] & ~true_prev_r[g];
      assign level_or_latch[g] = edge_all[g] ? latch_r[g] : true_now[g]; // R5 R6
    end
  endgenerate

  // A rise in the cycle of a read wins over the clear
  always @* begin
    latch_nxt = latch_r;
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin
      if (status_rd_in) begin
        latch_nxt[i] = 1'b0; // R7
      end
      if (rise[i]) begin
        latch_nxt[i] = 1'b1; // R6
      end
    end
    // Sense 2 in delayed-stop mode reports only when the line delay expires
    if (sense2_stop_r) begin
      latch_nxt[`ST_SENSE2_BIT] = latch_r[`ST_SENSE2_BIT] & ~status_rd_in;
      if (s2_fire) begin
        latch_nxt[`ST_SENSE2_BIT] = 1'b1; // R9
      end
    end
  end

  always @* begin
    status_nxt = level_or_latch;
    if (sense2_stop_r & ~sense_edge_r[1]) begin
      status_nxt[`ST_SENSE2_BIT] = sense2_true_r; // R9
    end
    // Pins driven as outputs read back their own pin level through polarity and edge select, like inputs
    status_nxt[`PIN_COUNT-1:`ST_GP_LSB] = level_or_latch[`PIN_COUNT-1:`ST_GP_LSB];
  end

  assign s1_rep_rise = status_nxt[`ST_SENSE1_BIT] & ~status_r[`ST_SENSE1_BIT];
  assign s2_pin_rise = rise[`ST_SENSE2_BIT];
  assign s2_fire = (d2_state_r == D2_WAIT) & line_tick_in & cnt_zero(d2_cnt_r);

  // Edge history and edge latches
  always @(posedge core_clk_in) begin
    if (sys_rst_in | suspend_in) begin
      true_prev_r <= {`PIN_COUNT{1'b0}};
      latch_r <= {`PIN_COUNT{1'b0}};
    end else begin
      true_prev_r <= true_now;
      latch_r <= latch_nxt;
    end
  end

  // Registered status seen by the host
  always @(posedge core_clk_in) begin
    if (sys_rst_in | suspend_in) begin
      status_r <= {`PIN_COUNT{1'b0}};
    end else begin
      status_r <= status_nxt;
    end
  end

  // Line-count delay for sense 2
  always @(posedge core_clk_in) begin
    if (sys_rst_in | suspend_in | soft_reset_in) begin
      d2_state_r <= D2_IDLE;
      d2_cnt_r <= {LINE_W{1'b0}};
      sense2_true_r <= 1'b0;
    end else begin
      case (d2_state_r)
        D2_IDLE: begin
          if (sense2_stop_r & s2_pin_rise) begin
            d2_state_r <= D2_WAIT;
            d2_cnt_r <= line_delay_r; // R9
            sense2_true_r <= 1'b0;
          end
        end
        D2_WAIT: begin
          if (line_tick_in) begin
            if (cnt_zero(d2_cnt_r)) begin
              d2_state_r <= D2_DONE;
              sense2_true_r <= 1'b1; // R9
            end else begin
              d2_cnt_r <= d2_cnt_r - CNT_ONE;
            end
          end
        end
        // Rearm only after the pin drops back to false
        D2_DONE: begin
          if (~true_now[`ST_SENSE2_BIT]) begin
            d2_state_r <= D2_IDLE;
            sense2_true_r <= 1'b0;
          end
        end
        default: begin
          d2_state_r <= D2_IDLE;
        end
      endcase
    end
  end

  // Sense 1 stops any move; sense 2 never stops a fast reverse move
  assign s1_stop_req = sense1_stop_r & s1_rep_rise; // R8
  assign s2_stop_req = s2_fire & ~fast_reverse_in; // R9 R10

  // One-cycle stop pulse to the motion controller
  always @(posedge core_clk_in) begin
    if (sys_rst_in | suspend_in) begin
      stop_r <= 1'b0;
    end else begin
      stop_r <= scanning_in & (s1_stop_req | s2_stop_req);
    end
  end

  // Status and configuration readback
  assign status_out = status_r;
  assign stop_scan_out = stop_r;
  assign gp_dir_out = gp_dir_r;
  assign gp_pol_out = gp_pol_r;
  assign gp_edge_out = gp_edge_r;
  assign gp_out_val_out = gp_out_r;
endmodule // media_sense_io

// ===== dv/media_sense_props.sv
// Port assertions for the media sense block
`timescale 1ns/1ps
module media_sense_checker (
  input wire core_clk_in,
  input wire sys_rst_in,
  input wire suspend_in,
  input wire soft_reset_in,
  input wire idle_in,
  input wire fast_reverse_in,
  input wire scanning_in,
  input wire cfg_we_in,
  input wire [5:0] gp_dir_in,
  input wire sense1_stop_en_in,
  input wire [7:0] status_out,
  input wire stop_scan_out,
  input wire [5:0] gp_pin_out,
  input wire [5:0] gp_pin_oe_n_out,
  input wire [5:0] gp_dir_out,
  input wire [5:0] gp_edge_out,
  input wire [5:0] gp_out_val_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in || suspend_in);
  a_reset_dflt: assert property ($fell(sys_rst_in) |-> gp_dir_out == 6'h38 && gp_out_val_out == 6'h18 &&
    gp_edge_out == 6'h07) else $error("defaults missing after reset");
  a_oe_dir: assert property (gp_pin_oe_n_out == ~gp_dir_out) else $error("enable does not follow direction");
  a_drive_val: assert property (gp_pin_out == gp_out_val_out) else $error("pin drive differs");
  a_cfg_taken: assert property (cfg_we_in && idle_in |=> gp_dir_out == $past(gp_dir_in))
    else $error("idle write lost");
  a_cfg_refused: assert property (cfg_we_in && !idle_in |=> $stable(gp_dir_out))
    else $error("busy write taken");
  a_soft_keep: assert property (soft_reset_in && !cfg_we_in |=> $stable(gp_dir_out) && $stable(gp_out_val_out))
    else $error("soft reset changed pins");
  a_s1_stop: assert property ($rose(status_out[0]) && scanning_in && sense1_stop_en_in |-> ##[0:1] stop_scan_out)
    else $error("no stop from sense 1");
  a_rev_hold: assert property ($past(fast_reverse_in) && !$rose(status_out[0]) |-> !stop_scan_out)
    else $error("reverse move stopped");
endmodule // media_sense_checker

// ===== dv/panel_model.sv
// Buttons with pull-ups, sensors and LEDs on the far side of the pins
`timescale 1ns/1ps
module panel_model (
  input wire [5:0] btn_in,
  input wire [1:0] sens_in,
  input wire [5:0] drv_in,
  input wire [5:0] oe_n_in,
  output wire [5:0] pin_out,
  output wire [1:0] sense_out
);
  assign pin_out = (oe_n_in & btn_in) | (~oe_n_in & drv_in);
  assign sense_out = sens_in;
endmodule // panel_model

// ===== dv/media_sense_io_bench.sv
// Self-checking bench for the media sense block
`timescale 1ns/1ps
module media_sense_io_bench;
  logic core_clk_in, sys_rst_in, suspend_in, soft_reset_in, idle_in, line_tick_in, fast_reverse_in;
  logic scanning_in, cfg_we_in, status_rd_in, s1e, s2e, stop;
  logic [5:0] btn, dir, pol, edg, outv, gp_pin_in, gp_pin_out, oe_n, dir_o, pol_o, edg_o, out_o;
  logic [1:0] sens, sense_pin_in, spol, sedg;
  logic [7:0] dly, status_out;
  int bad_count, n_compared, stops;
  media_sense_io media_sense_io_i (.core_clk_in, .sys_rst_in, .suspend_in, .soft_reset_in, .idle_in,
    .line_tick_in, .fast_reverse_in, .scanning_in, .sense_pin_in, .gp_pin_in, .gp_pin_out,
    .gp_pin_oe_n_out(oe_n), .cfg_we_in, .gp_dir_in(dir), .gp_pol_in(pol), .gp_edge_in(edg),
    .gp_out_in(outv), .sense_pol_in(spol), .sense_edge_in(sedg), .sense1_stop_en_in(s1e),
    .sense2_stop_en_in(s2e), .line_delay_in(dly), .status_rd_in, .status_out, .stop_scan_out(stop),
    .gp_dir_out(dir_o), .gp_pol_out(pol_o), .gp_edge_out(edg_o), .gp_out_val_out(out_o));
  panel_model panel_model_i (.btn_in(btn), .sens_in(sens), .drv_in(gp_pin_out), .oe_n_in(oe_n),
    .pin_out(gp_pin_in), .sense_out(sense_pin_in));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (stop === 1'b1) stops++;
  task chk(input [7:0] g, input [7:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task cfg(input [5:0] d, input [5:0] p, input [5:0] e, input [5:0] o);
    {dir, pol, edg, outv, cfg_we_in} = {d, p, e, o, 1'b1};
    cyc(1);
    cfg_we_in = 1'b0;
  endtask
  task rd;
    status_rd_in = 1'b1;
    cyc(1);
    status_rd_in = 1'b0;
    cyc(1);
  endtask
  task tick;
    line_tick_in = 1'b1;
    cyc(1);
    line_tick_in = 1'b0;
    cyc(3);
  endtask
  task t_defaults;
    chk({2'h0, dir_o}, 8'h38);
    chk({2'h0, edg_o}, 8'h07);
    chk({2'h0, out_o}, 8'h18);
    chk({2'h0, pol_o}, 8'h00);
  endtask
  task t_edge;
    for (int i = 0; i < 3; i++) begin
      rd;
      btn[i] = 1'b0;
      cyc(6);
      btn[i] = 1'b1;
      cyc(6);
      chk(status_out & 8'h1C, 8'h04 << i);
      rd;
      chk(status_out & 8'h1C, 8'h00);
    end
  endtask
  task t_level;
    cfg(6'h00, 6'h3F, 6'h00, 6'h00);
    btn = 6'h2A;
    cyc(6);
    chk({2'h0, status_out[7:2]}, 8'h2A);
    btn = 6'h15;
    cyc(6);
    chk({2'h0, status_out[7:2]}, 8'h15);
    cfg(6'h00, 6'h00, 6'h00, 6'h00);
    cyc(6);
    chk({2'h0, status_out[7:2]}, 8'h2A);
    cfg(6'h3F, 6'h00, 6'h00, 6'h25);
    cyc(6);
    chk({2'h0, gp_pin_out}, 8'h25);
    chk({2'h0, status_out[7:2]}, 8'h1A);
  endtask
  task t_refuse;
    idle_in = 1'b0;
    cfg(6'h00, 6'h00, 6'h00, 6'h00);
    chk({2'h0, dir_o}, 8'h3F);
    {idle_in, soft_reset_in} = 2'b11;
    cyc(3);
    soft_reset_in = 1'b0;
    cyc(1);
    chk({2'h0, out_o}, 8'h25);
  endtask
  task t_sense(input int s0);
    {s1e, scanning_in, sens} = 4'b1100;
    cfg(6'h00, 6'h3F, 6'h00, 6'h00);
    s0 = stops;
    sens[0] = 1'b1;
    cyc(8);
    chk(8'(stops - s0), 8'h01);
    {s1e, s2e, dly, sens} = {2'b01, 8'h02, 2'b00};
    cfg(6'h00, 6'h3F, 6'h00, 6'h00);
    sens[1] = 1'b1;
    cyc(6);
    tick;
    tick;
    chk({7'h0, status_out[1]}, 8'h00);
    tick;
    chk({7'h0, status_out[1]}, 8'h01);
    chk(8'(stops - s0), 8'h02);
    {sens[1], fast_reverse_in} = 2'b01;
    cyc(6);
    sens[1] = 1'b1;
    cyc(6);
    repeat (4) tick;
    chk(8'(stops - s0), 8'h02);
    {s2e, sedg} = {1'b0, 2'b01};
    cfg(6'h00, 6'h3F, 6'h00, 6'h00);
    rd;
    sens[0] = 1'b1;
    cyc(6);
    sens[0] = 1'b0;
    cyc(6);
    chk({7'h0, status_out[0]}, 8'h01);
    rd;
    chk({7'h0, status_out[0]}, 8'h00);
    {s2e, scanning_in, fast_reverse_in, sens, sedg} = '0;
  endtask
  task wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {suspend_in, soft_reset_in, line_tick_in, fast_reverse_in, scanning_in, cfg_we_in, status_rd_in} = '0;
    {s1e, s2e, dir, pol, edg, outv, sens, sedg, dly} = '0;
    {sys_rst_in, idle_in, btn, spol} = {2'b11, 6'h3F, 2'h3};
    cyc(20);
    sys_rst_in = 1'b0;
    cyc(1);
    t_defaults;
    t_edge;
    t_level;
    t_refuse;
    t_sense(0);
    suspend_in = 1'b1;
    cyc(2);
    suspend_in = 1'b0;
    cyc(1);
    t_defaults;
    wrap_up;
  end
  // Whole run is well under 1000 cycles; give it a wide margin
  initial begin
    #40000;
    bad_count++;
    wrap_up;
  end
endmodule // media_sense_io_bench
bind media_sense_io media_sense_checker media_sense_checker_i (.core_clk_in, .sys_rst_in, .suspend_in,
  .soft_reset_in, .idle_in, .fast_reverse_in, .scanning_in, .cfg_we_in, .gp_dir_in, .sense1_stop_en_in,
  .status_out, .stop_scan_out, .gp_pin_out, .gp_pin_oe_n_out, .gp_dir_out, .gp_edge_out, .gp_out_val_out);
